//--- hw/fea_top.sv
// Purpose: Fundamental energy accumulators, low range linearity and aux RMS result.
// Assumes: Host register port is byte addressed; read data follows one cycle later.
// Notes: Overflow flags clear by writing ones; reserved bits read as zero.
`timescale 1ns/1ns
module fea_top
	import fea_pkg::*;
#(
	parameter int RMS_W = 32
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Host register port
	input wire logic [FEA_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [FEA_DATA_W-1:0] reg_wdata,
	output logic [FEA_DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// DSP cycle energies, phase A in the low word
	input wire logic dsp_cycle,
	input wire logic [FEA_PHASES*32-1:0] fund_real_cycle_energy,
	input wire logic [FEA_PHASES*32-1:0] fund_reactive_cycle_energy,
	input wire logic [FEA_PHASES*32-1:0] fund_apparent_energy,
	// Low range linearity
	input wire logic [FEA_PHASES-1:0] pga_gain32,
	input wire logic linearity_form_select,
	input wire logic [FEA_PHASES*FEA_GAIN_W-1:0] low_range_linearity_gain,
	input wire logic [FEA_PHASES*RMS_W-1:0] phase_current_rms,
	output logic [FEA_PHASES*RMS_W-1:0] comp_current,
	// Auxiliary channel
	input wire logic aux_rms_valid,
	input wire logic [FEA_SEL_W-1:0] aux_source_select,
	input wire logic [31:0] neutral_rms,
	input wire logic [31:0] harmonic_rms
);
	function automatic logic fea_hit(input fea_addr_t a, input fea_addr_t b);
		return a == b;
	endfunction

	// Bit-serial square root; wide but purely combinational, so no extra latency.
	function automatic logic [31:0] fea_isqrt(input logic [63:0] v);
		logic [31:0] r;
		logic [31:0] c;
		r = '0;
		for (int i = 31; i >= 0; i--) begin
			c = r | (32'h1 << i);
			if (64'(c) * 64'(c) <= v) r = c;
		end
		return r;
	endfunction

	// Gain is unsigned with fourteen fraction bits; results above range saturate.
	function automatic logic [RMS_W-1:0] fea_scale(input logic [FEA_GAIN_W-1:0] g,
		input logic [RMS_W:0] v);
		logic [FEA_GAIN_W+RMS_W:0] p;
		p = (FEA_GAIN_W+RMS_W+1)'(g) * (FEA_GAIN_W+RMS_W+1)'(v);
		if ((p >> (FEA_GAIN_SHIFT + RMS_W)) != 0) return '1;
		return p[FEA_GAIN_SHIFT +: RMS_W];
	endfunction

	logic [FEA_OFFS_W-1:0] lin_offs [FEA_PHASES];
	logic [31:0] aux_rms;
	wire logic [FEA_DATA_W-1:0] ph_rd [FEA_PHASES];
	wire logic [RMS_W-1:0] comp_next [FEA_PHASES];
	wire logic aux_hit = fea_hit(reg_addr, FEA_AUX_RMS_ADDR);
	wire logic aux_harm = aux_source_select != FEA_AUX_NEUTRAL;
	wire logic [31:0] next_aux_rms = aux_harm ? harmonic_rms : neutral_rms;

	for (genvar p = 0; p < FEA_PHASES; p++) begin : g_ph
		fea_acc_if acc_if();
		wire logic hit_offs = fea_hit(reg_addr, FEA_OFFS_ADDR[p]);
		wire logic hit_ovf = fea_hit(reg_addr, FEA_OVF_ADDR[p]);
		wire logic hit_rp = fea_hit(reg_addr, FEA_RP_ADDR[p]);
		wire logic hit_rn = fea_hit(reg_addr, FEA_RN_ADDR[p]);
		wire logic [RMS_W-1:0] rms = phase_current_rms[p*RMS_W +: RMS_W];
		wire logic [FEA_GAIN_W-1:0] gain = low_range_linearity_gain[p*FEA_GAIN_W +: FEA_GAIN_W];
		wire logic [63:0] rms_sq = 64'(rms) * 64'(rms);
		wire logic signed [65:0] offs_sh = 66'(signed'(lin_offs[p])) <<< FEA_OFFS_SHIFT;
		wire logic signed [65:0] rad = $signed({2'b00, rms_sq}) + offs_sh;
		// A negative radicand clamps to zero rather than wrapping to a huge root.
		wire logic [63:0] rad_c = rad[65] ? 64'h0 : (rad[64] ? '1 : rad[63:0]);
		wire logic signed [RMS_W+1:0] lin_sum = $signed({2'b00, rms})
			+ (RMS_W+2)'(signed'(lin_offs[p]));
		wire logic [RMS_W:0] lin_c = lin_sum[RMS_W+1] ? '0 : lin_sum[RMS_W:0];
		wire logic [RMS_W-1:0] form0 = fea_scale(gain, (RMS_W+1)'(fea_isqrt(rad_c)));
		wire logic [RMS_W-1:0] form1 = fea_scale(gain, lin_c);
		wire logic [RMS_W-1:0] next_comp = !pga_gain32[p] ? rms
			: (linearity_form_select ? form1 : form0);

		assign acc_if.dsp_cycle = dsp_cycle;
		assign acc_if.real_e = fund_real_cycle_energy[p*32 +: 32];
		assign acc_if.react_e = fund_reactive_cycle_energy[p*32 +: 32];
		assign acc_if.app_e = fund_apparent_energy[p*32 +: 32];
		// Host clears flags by writing ones; a same-cycle overflow still wins.
		assign acc_if.clr = (reg_wr && hit_ovf) ? reg_wdata[FEA_OVF_W-1:0] : '0;
		assign comp_next[p] = next_comp;
		assign ph_rd[p] = hit_offs ? FEA_DATA_W'(lin_offs[p])
			: hit_ovf ? FEA_DATA_W'({3'h0, acc_if.flags})
			: hit_rp ? acc_if.acc_rp
			: hit_rn ? acc_if.acc_rn : '0;

		fea_phase_acc u_acc (
			.clk_sys(clk_sys),
			.nrst(nrst),
			.acc(acc_if)
		);

		always_ff @(posedge clk_sys) begin
			if (!nrst) lin_offs[p] <= FEA_OFFS_RESET;
			else if (reg_wr && hit_offs) lin_offs[p] <= reg_wdata[FEA_OFFS_W-1:0];
		end
	end

	// One process owns the whole output vector, so no slice of it has two writers.
	always_ff @(posedge clk_sys) begin
		for (int q = 0; q < FEA_PHASES; q++) begin
			if (!nrst) comp_current[q*RMS_W +: RMS_W] <= '0;
			else comp_current[q*RMS_W +: RMS_W] <= comp_next[q];
		end
	end

	wire logic [FEA_DATA_W-1:0] aux_rd = aux_hit ? aux_rms : '0;
	// Unmapped addresses read as zero; the answer still comes one cycle later.
	wire logic [FEA_DATA_W-1:0] next_rdata = ph_rd[0] | ph_rd[1] | ph_rd[2] | aux_rd;

	always_ff @(posedge clk_sys) begin
		if (!nrst) aux_rms <= FEA_ACC_RESET;
		else if (aux_rms_valid) aux_rms <= next_aux_rms;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : reg_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_offs_reset_zero: assert property ($rose(nrst) |-> lin_offs[0] == FEA_OFFS_RESET
		&& lin_offs[2] == FEA_OFFS_RESET)
		else $error("linearity offset not zero after reset");
	a_comp_bypass_hi: assert property (!pga_gain32[0]
		|=> comp_current[RMS_W-1:0] == $past(phase_current_rms[RMS_W-1:0]))
		else $error("compensation applied outside gain 32");
	a_comp_form_one: assert property (pga_gain32[0] && linearity_form_select
		|=> comp_current[RMS_W-1:0] == $past(g_ph[0].form1))
		else $error("form one compensation wrong");
	a_comp_form_zero: assert property (pga_gain32[0] && !linearity_form_select
		|=> comp_current[RMS_W-1:0] == $past(g_ph[0].form0))
		else $error("form zero compensation wrong");
	a_aux_neutral_src: assert property (aux_rms_valid && !aux_harm ##1 !aux_rms_valid
		##1 reg_rd && aux_hit |=> reg_rvalid && reg_rdata == $past(neutral_rms, 3))
		else $error("aux result not neutral RMS");
	a_aux_harm_src: assert property (aux_rms_valid && aux_harm |=> aux_rms == $past(harmonic_rms))
		else $error("aux result not harmonic RMS");
	a_ovf_read_map: assert property (reg_rd && g_ph[1].hit_ovf |=> reg_rvalid
		&& reg_rdata[31:FEA_OVF_W] == '0
		&& reg_rdata[FEA_OVF_W-1:0] == $past(g_ph[1].acc_if.flags))
		else $error("overflow flag read wrong");
	a_read_one_cycle: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
		else $error("read answer timing wrong");
	c_form0_used: cover property (pga_gain32[0] && !linearity_form_select && dsp_cycle);
	c_flag_cleared: cover property (g_ph[0].acc_if.flags != 0 ##1 g_ph[0].acc_if.clr != 0);
	c_aux_harm: cover property (aux_rms_valid && aux_harm);
endmodule

//--- hw/fea_pkg.sv
// Purpose: Shared constants for the fundamental energy accumulator block.
// Assumes: Byte addressed register port with 10-bit addresses.
// Notes: Register offsets are the printed ones, not word indices.
package fea_pkg;
	localparam int FEA_PHASES = 3;
	localparam int FEA_ADDR_W = 10;
	localparam int FEA_DATA_W = 32;
	localparam int FEA_OFFS_W = 16;
	localparam int FEA_GAIN_W = 16;
	localparam int FEA_SEL_W = 3;
	typedef logic [FEA_ADDR_W-1:0] fea_addr_t;
	typedef logic [FEA_DATA_W-1:0] fea_word_t;
	localparam fea_addr_t FEA_AUX_RMS_ADDR = 10'h11c;
	localparam fea_addr_t FEA_OFFS_ADDR [FEA_PHASES] = '{10'h13c, 10'h228, 10'h314};
	localparam fea_addr_t FEA_OVF_ADDR [FEA_PHASES] = '{10'h147, 10'h233, 10'h31f};
	localparam fea_addr_t FEA_RP_ADDR [FEA_PHASES] = '{10'h1fc, 10'h2e8, 10'h3d4};
	localparam fea_addr_t FEA_RN_ADDR [FEA_PHASES] = '{10'h200, 10'h2fc, 10'h3d8};
	// Overflow flag bit positions.
	localparam int FEA_OVF_RP = 0;
	localparam int FEA_OVF_RN = 1;
	localparam int FEA_OVF_QP = 2;
	localparam int FEA_OVF_QN = 3;
	localparam int FEA_OVF_S = 4;
	localparam int FEA_OVF_W = 5;
	localparam int FEA_OVF_REG_W = 8;
	localparam logic [FEA_OVF_W-1:0] FEA_OVF_RESET = 5'h00;
	localparam logic [FEA_OFFS_W-1:0] FEA_OFFS_RESET = 16'h0000;
	localparam fea_word_t FEA_ACC_RESET = 32'h0000_0000;
	localparam int FEA_GAIN_SHIFT = 14;
	localparam int FEA_OFFS_SHIFT = 16;
	// Auxiliary source code that selects the neutral current channel.
	localparam logic [FEA_SEL_W-1:0] FEA_AUX_NEUTRAL = 3'h0;
endpackage

//--- hw/fea_acc_if.sv
// Purpose: Carries one phase's cycle energies, clears and accumulator state.
// Assumes: One instance per phase, joined inside the top module.
// Notes: Energies are two's complement except apparent energy.
`timescale 1ns/1ns
interface fea_acc_if;
	logic dsp_cycle;
	logic signed [31:0] real_e;
	logic signed [31:0] react_e;
	logic [31:0] app_e;
	logic [4:0] clr;
	logic [31:0] acc_rp;
	logic [31:0] acc_rn;
	logic [31:0] acc_qp;
	logic [31:0] acc_qn;
	logic [31:0] acc_s;
	logic [4:0] flags;
	modport ctrl(output dsp_cycle, real_e, react_e, app_e, clr,
		input acc_rp, acc_rn, acc_qp, acc_qn, acc_s, flags);
	modport acc(input dsp_cycle, real_e, react_e, app_e, clr,
		output acc_rp, acc_rn, acc_qp, acc_qn, acc_s, flags);
endinterface

//--- hw/fea_phase_acc.sv
// Purpose: Five fundamental energy accumulators and sticky overflow flags of one phase.
// Assumes: dsp_cycle is a one-cycle strobe with the cycle energies valid beside it.
// Notes: A flag set in the same cycle as a host clear stays set.
`timescale 1ns/1ns
module fea_phase_acc
	import fea_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Phase channel
	fea_acc_if.acc acc
);
	wire logic real_pos = acc.dsp_cycle && !acc.real_e[31] && (acc.real_e != 0);
	wire logic real_neg = acc.dsp_cycle && acc.real_e[31];
	wire logic react_pos = acc.dsp_cycle && !acc.react_e[31] && (acc.react_e != 0);
	wire logic react_neg = acc.dsp_cycle && acc.react_e[31];
	// Negation of the most negative value still fits as an unsigned magnitude.
	wire logic [31:0] real_mag = 32'(-acc.real_e);
	wire logic [31:0] react_mag = 32'(-acc.react_e);
	wire logic [32:0] sum_rp = {1'b0, acc.acc_rp} + {1'b0, acc.real_e};
	wire logic [32:0] sum_rn = {1'b0, acc.acc_rn} + {1'b0, real_mag};
	wire logic [32:0] sum_qp = {1'b0, acc.acc_qp} + {1'b0, acc.react_e};
	wire logic [32:0] sum_qn = {1'b0, acc.acc_qn} + {1'b0, react_mag};
	wire logic [32:0] sum_s = {1'b0, acc.acc_s} + {1'b0, acc.app_e};
	wire logic [4:0] set_ovf = {acc.dsp_cycle && sum_s[32], react_neg && sum_qn[32],
		react_pos && sum_qp[32], real_neg && sum_rn[32], real_pos && sum_rp[32]};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			acc.acc_rp <= FEA_ACC_RESET;
			acc.acc_rn <= FEA_ACC_RESET;
			acc.acc_qp <= FEA_ACC_RESET;
			acc.acc_qn <= FEA_ACC_RESET;
			acc.acc_s <= FEA_ACC_RESET;
		end else begin
			if (real_pos) acc.acc_rp <= sum_rp[31:0];
			if (real_neg) acc.acc_rn <= sum_rn[31:0];
			if (react_pos) acc.acc_qp <= sum_qp[31:0];
			if (react_neg) acc.acc_qn <= sum_qn[31:0];
			if (acc.dsp_cycle) acc.acc_s <= sum_s[31:0];
		end
	end

	// Flags only record a wrap; they never hold back accumulation.
	always_ff @(posedge clk_sys) begin
		if (!nrst) acc.flags <= FEA_OVF_RESET;
		else acc.flags <= (acc.flags & ~acc.clr) | set_ovf;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_rp_acc_add: assert property (real_pos |=> acc.acc_rp == $past(sum_rp[31:0]))
		else $error("real positive accumulator did not add");
	a_rn_acc_add: assert property (real_neg |=> acc.acc_rn == 32'($past(acc.acc_rn)
		- $past(acc.real_e)))
		else $error("real negative accumulator did not add magnitude");
	a_rp_flag_set: assert property (real_pos && sum_rp[32]
		|=> acc.flags[FEA_OVF_RP] && acc.acc_rp < $past(acc.acc_rp))
		else $error("real positive wrap did not set flag");
	a_rn_flag_set: assert property (real_neg && sum_rn[32] |=> acc.flags[FEA_OVF_RN])
		else $error("real negative wrap did not set flag");
	a_flag_sticky_hold: assert property (acc.flags[FEA_OVF_RP] && !acc.clr[FEA_OVF_RP]
		|=> acc.flags[FEA_OVF_RP])
		else $error("overflow flag dropped without host clear");
	a_react_neg_acc: assert property (react_neg |=> acc.acc_qn == 32'($past(acc.acc_qn)
		- $past(acc.react_e)))
		else $error("reactive negative accumulator did not add");
	a_app_flag_set: assert property (acc.dsp_cycle && sum_s[32] |=> acc.flags[FEA_OVF_S])
		else $error("apparent wrap did not set flag");
	a_flag_no_block: assert property (real_pos && acc.flags[FEA_OVF_RP]
		|=> acc.acc_rp != $past(acc.acc_rp) || $past(acc.real_e) == 0)
		else $error("set flag stalled accumulation");
	a_wrap_low_bits: assert property (real_pos && sum_rp[32]
		|=> acc.acc_rp == 32'($past(acc.acc_rp) + $past(acc.real_e)))
		else $error("wrap did not keep low word");
	c_rp_wrap: cover property (real_pos && sum_rp[32]);
	c_clear_race: cover property (set_ovf[FEA_OVF_RN] && acc.clr[FEA_OVF_RN]);
endmodule

//--- tb/fea_host_model.sv
// Purpose: Host master model that drives the register port of the accumulator block.
// Assumes: Requests launch on a falling edge and are taken on the next rising edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ns
module fea_host_model
	import fea_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [FEA_ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [FEA_DATA_W-1:0] reg_wdata
);
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
	end
	task automatic reg_access(input logic wr, input fea_addr_t a, input fea_word_t d);
		@(negedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(negedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// Flags are sticky, so only this write-one-to-clear access lowers them.
	task automatic clear_flags(input int p, input logic [4:0] mask);
		reg_access(1'b1, FEA_OVF_ADDR[p], {27'h0, mask});
	endtask
	// A set flag is no error; it means the counter wrapped since the host last cleared the flag.
	function automatic logic [32:0] energy_delta(fea_word_t prev, fea_word_t cur, logic ovf);
		return {1'b0, cur} - {1'b0, prev} + (ovf ? 33'h1_0000_0000 : 33'h0);
	endfunction
endmodule

//--- tb/test_fea_top.sv
// Purpose: Self-checking bench for the fundamental energy accumulator block.
// Assumes: Inputs change on the falling edge; reads answer one cycle after the request.
// Notes: Accumulators, flags and compensation are modelled here from the register rules.
`timescale 1ns/1ns
`define fea_cmp(g, e, m) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: %s", $time, m); end end
module test_fea_top;
	import fea_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0, dsp_cycle = 1'b0, linearity_form_select = 1'b0;
	logic [FEA_ADDR_W-1:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid, aux_rms_valid = 1'b0;
	logic [FEA_DATA_W-1:0] reg_wdata, reg_rdata;
	logic [95:0] fund_real_cycle_energy = '0, fund_reactive_cycle_energy = '0;
	logic [95:0] fund_apparent_energy = '0, phase_current_rms = '0, comp_current;
	logic [2:0] pga_gain32 = '0, aux_source_select = '0;
	logic [47:0] low_range_linearity_gain = '0;
	logic [31:0] neutral_rms = '0, harmonic_rms = '0, rng_s = 32'h0000_0058;
	logic [31:0] m_rp [3], m_rn [3], m_qp [3], m_qn [3], m_s [3];
	logic [4:0] m_fl [3];
	logic [15:0] m_off [3];
	fea_word_t exp_q [$];
	int failures = 0, checks_done = 0;
	always #2 clk_sys = ~clk_sys;
	fea_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));
	fea_top #(.RMS_W(32)) uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .dsp_cycle(dsp_cycle),
		.fund_real_cycle_energy(fund_real_cycle_energy),
		.fund_reactive_cycle_energy(fund_reactive_cycle_energy),
		.fund_apparent_energy(fund_apparent_energy), .pga_gain32(pga_gain32),
		.linearity_form_select(linearity_form_select),
		.low_range_linearity_gain(low_range_linearity_gain),
		.phase_current_rms(phase_current_rms), .comp_current(comp_current),
		.aux_rms_valid(aux_rms_valid), .aux_source_select(aux_source_select),
		.neutral_rms(neutral_rms), .harmonic_rms(harmonic_rms));
	function logic [31:0] rnd();
		rng_s = rng_s ^ (rng_s << 13);
		rng_s = rng_s ^ (rng_s >> 17);
		rng_s = rng_s ^ (rng_s << 5);
		return rng_s;
	endfunction
	function automatic logic [67:0] isqrt(logic [67:0] v);
		logic [67:0] r, t;
		r = '0;
		for (int b = 33; b >= 0; b--) begin
			t = r | (68'h1 << b);
			if (t * t <= v) r = t;
		end
		return r;
	endfunction
	function automatic logic [31:0] comp_exp(logic [31:0] rms, logic signed [15:0] off,
		logic [15:0] g, logic pga, logic form);
		logic signed [67:0] inner;
		logic [67:0] prod;
		if (!pga) return rms;
		inner = $signed({36'h0, rms});
		if (form) inner = inner + off;
		else inner = inner * inner + off * 68'sh10000;
		if (inner < 0) inner = '0;
		prod = ((form ? inner : isqrt(inner)) * g) >> 14;
		return (prod > 68'hffff_ffff) ? 32'hffff_ffff : prod[31:0];
	endfunction
	// A carry out of bit 31 sets the flag while the sum keeps its low 32 bits.
	task automatic acc_add(inout logic [31:0] a, inout logic [4:0] f, input logic [31:0] v,
		input int b);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, v};
		a = s[31:0];
		if (s[32]) f[b] = 1'b1;
	endtask
	task automatic dsp_step();
		logic [31:0] r, q;
		@(negedge clk_sys);
		for (int p = 0; p < 3; p++) begin
			r = rnd();
			q = rnd();
			fund_real_cycle_energy[p*32 +: 32] = r;
			fund_reactive_cycle_energy[p*32 +: 32] = q;
			fund_apparent_energy[p*32 +: 32] = rnd();
			if (r[31]) acc_add(m_rn[p], m_fl[p], -r, FEA_OVF_RN);
			else acc_add(m_rp[p], m_fl[p], r, FEA_OVF_RP);
			if (q[31]) acc_add(m_qn[p], m_fl[p], -q, FEA_OVF_QN);
			else acc_add(m_qp[p], m_fl[p], q, FEA_OVF_QP);
			acc_add(m_s[p], m_fl[p], fund_apparent_energy[p*32 +: 32], FEA_OVF_S);
		end
		dsp_cycle = 1'b1;
		@(negedge clk_sys);
		dsp_cycle = 1'b0;
		fund_real_cycle_energy = {rnd(), rnd(), rnd()};
	endtask
	task automatic rd_expect(input fea_addr_t a, input fea_word_t e);
		exp_q.push_back(e);
		host.reg_access(1'b0, a, rnd());
	endtask
	task automatic check_all();
		for (int p = 0; p < 3; p++) begin
			rd_expect(FEA_RP_ADDR[p], m_rp[p]);
			rd_expect(FEA_RN_ADDR[p], m_rn[p]);
			rd_expect(FEA_OVF_ADDR[p], {27'h0, m_fl[p]});
			rd_expect(FEA_OFFS_ADDR[p], {16'h0, m_off[p]});
		end
	endtask
	always @(negedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("wrong value at %0t: read answer without request", $time);
			end else `fea_cmp(reg_rdata, exp_q.pop_front(), "read data")
		end
	end
	task automatic complete_run();
		$display("checks_done %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	initial begin
		for (int p = 0; p < 3; p++) begin
			{m_rp[p], m_rn[p], m_qp[p], m_qn[p], m_s[p]} = '0;
			m_fl[p] = FEA_OVF_RESET;
			m_off[p] = FEA_OFFS_RESET;
		end
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		check_all();
		rd_expect(FEA_AUX_RMS_ADDR, 32'h0);
		rd_expect(10'h3ff, 32'h0);
		host.reg_access(1'b1, FEA_RP_ADDR[1], rnd());
		for (int p = 0; p < 3; p++) begin
			m_off[p] = 16'(rnd());
			host.reg_access(1'b1, FEA_OFFS_ADDR[p], (rnd() & 32'hffff_0000) | {16'h0, m_off[p]});
		end
		check_all();
		for (int r = 0; r < 4; r++) begin
			repeat (7) dsp_step();
			check_all();
			for (int p = 0; p < 3; p++) begin
				logic [4:0] mk;
				mk = rnd();
				host.clear_flags(p, mk);
				m_fl[p] = m_fl[p] & ~mk;
			end
		end
		check_all();
		for (int s = 0; s < 8; s++) begin
			@(negedge clk_sys);
			aux_source_select = 3'(s);
			neutral_rms = rnd();
			harmonic_rms = rnd();
			aux_rms_valid = 1'b1;
			@(negedge clk_sys);
			aux_rms_valid = 1'b0;
			rd_expect(FEA_AUX_RMS_ADDR, (s == 0) ? neutral_rms : harmonic_rms);
		end
		for (int k = 0; k < 24; k++) begin
			@(negedge clk_sys);
			linearity_form_select = rnd();
			pga_gain32 = rnd();
			low_range_linearity_gain = {rnd(), rnd()};
			phase_current_rms = {rnd(), rnd(), rnd()} & {3{(k[0] ? 32'hffff_ffff : 32'h000f_ffff)}};
			@(negedge clk_sys);
			for (int p = 0; p < 3; p++)
				`fea_cmp(comp_current[p*32 +: 32], comp_exp(phase_current_rms[p*32 +: 32], m_off[p],
					low_range_linearity_gain[p*16 +: 16], pga_gain32[p], linearity_form_select),
					"compensated current")
		end
		for (int w = 0; w < 10 && exp_q.size() != 0; w++) @(negedge clk_sys);
		if (exp_q.size() != 0) failures++;
		complete_run();
	end
endmodule
